// ---- logic/dmacr_fifo.sv ----
// transfer command fifo with registered output stage
`timescale 1ns/100ps
module dmacr_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 4
) (
	input  wire logic             pclk,      // system clock
	input  wire logic             presetn,   // async reset, active low
	input  wire logic             ce,        // clock enable
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // room available
	input  wire logic [WIDTH-1:0] in_data,   // write data
	output logic                  out_valid, // output word valid
	input  wire logic             out_ready, // consumer takes word
	output logic      [WIDTH-1:0] out_data   // output word
);
	// the output register is one of the DEPTH slots, the array holds the rest
	localparam int AD = DEPTH - 1;
	localparam int PW = (AD > 1) ? $clog2(AD) : 1;
	localparam int CW = $clog2(AD + 1);

	initial begin
		if (DEPTH < 2)
			$error("fifo depth must be at least 2");
	end

	logic [AD-1:0][WIDTH-1:0] mem_r, mem_nxt;
	logic [PW-1:0]            wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0]            cnt_r, cnt_nxt;
	logic                     ov_nxt;
	logic [WIDTH-1:0]         od_nxt;
	logic                     push, load;

	function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
		wrap_inc = (p == PW'(AD - 1)) ? '0 : PW'(p + 1'b1);
	endfunction : wrap_inc

	assign in_ready = (cnt_r != CW'(AD));

	// array bookkeeping and output stage refill
	always_comb begin
		push    = in_valid && in_ready;
		load    = (!out_valid || out_ready) && (cnt_r != '0);
		mem_nxt = mem_r;
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		ov_nxt  = out_valid;
		od_nxt  = out_data;
		if (push) begin
			mem_nxt[wp_r] = in_data;
			wp_nxt        = wrap_inc(wp_r);
		end
		if (load) begin
			od_nxt = mem_r[rp_r];
			ov_nxt = 1'b1;
			rp_nxt = wrap_inc(rp_r);
		end else if (out_ready) begin
			ov_nxt = 1'b0;
		end
		cnt_nxt = CW'(cnt_r + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, load});
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_r     <= '0;
			wp_r      <= '0;
			rp_r      <= '0;
			cnt_r     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (ce) begin
			mem_r     <= mem_nxt;
			wp_r      <= wp_nxt;
			rp_r      <= rp_nxt;
			cnt_r     <= cnt_nxt;
			out_valid <= ov_nxt;
			out_data  <= od_nxt;
		end
	end
endmodule : dmacr_fifo

// ---- logic/dmacr_pkg.sv ----
// shared constants for the two-channel transfer controller enable and request logic
package dmacr_pkg;
	localparam int NCHAN = 2;             // channel_zero and channel_one
	localparam int NSRC  = 4;             // request source lines
	localparam int SEL_W = 2;             // request source select width
	localparam int PADDR_W = 8;           // apb address width
	localparam int PDATA_W = 32;          // apb data width
	localparam int ADDR_W_DEF = 20;       // pointer width default
	localparam int CNT_W_DEF  = 16;       // transfer counter width default
	localparam int FIFO_DEPTH_DEF = 4;    // transfer command fifo depth
	// byte offsets inside one channel window
	localparam logic [2:0] REG_CTRL   = 3'h0; // control: 0x00
	localparam logic [2:0] REG_SRC    = 3'h1; // source pointer: 0x04
	localparam logic [2:0] REG_DST    = 3'h2; // destination pointer: 0x08
	localparam logic [2:0] REG_FWD    = 3'h3; // forward address pointer (ro): 0x0c
	localparam logic [2:0] REG_RELOAD = 3'h4; // transfer counter reload: 0x10
	localparam logic [2:0] REG_COUNT  = 3'h5; // transfer counter (ro): 0x14
	localparam int CHAN_BIT  = 5;         // address bit selecting the channel window (0x20)
	// control register fields
	localparam int CTRL_SEL_LSB = 0;      // request source select [1:0]
	localparam int CTRL_REQ_BIT = 2;      // pending request flag
	localparam int CTRL_EN_BIT  = 3;      // channel active enable
	localparam int CTRL_DIR_BIT = 4;      // 0: source is forward, 1: destination is forward
	// reset values
	localparam logic             EN_RST  = 1'b0;
	localparam logic             REQ_RST = 1'b0;
	localparam logic             DIR_RST = 1'b0;
	localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
endpackage : dmacr_pkg

// ---- logic/dmacr_sync.sv ----
// two flip-flop synchroniser for request source pins
`timescale 1ns/100ps
module dmacr_sync #(
	parameter int W = 4
) (
	input  wire logic         pclk,    // system clock
	input  wire logic         presetn, // async reset, active low
	input  wire logic         ce,      // clock enable
	input  wire logic [W-1:0] d,       // asynchronous input
	output logic      [W-1:0] q        // synchronised output
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// only the second stage is ever looked at, so metastability stays contained
	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q      <= '0;
		end else if (ce) begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end
endmodule : dmacr_sync

// ---- logic/dmacr_top.sv ----
// What this block does
// - control register bit 3 is the channel active enable; writing one activates.
// - enable written one copies the configured forward pointer into the forward address.
// - enable written one loads the transfer counter from its reload register.
// - enable written one on an active channel restarts it, discarding progress.
// - control register bit 2 is the pending request flag.
// - selected request source sets the flag, whether enabled or not.
// - the flag clears when a data transfer for that channel begins.
// - software writing zero clears the flag; writing one does nothing.
// - changing the source select may itself set the flag spuriously.
// - an active channel with the flag set starts a transfer once the fifo has room, channel_zero first on a tie.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module dmacr_top
	import dmacr_pkg::*;
#(
	parameter int ADDR_W     = ADDR_W_DEF,
	parameter int CNT_W      = CNT_W_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input  wire logic                 pclk,       // system clock, 40 mhz
	input  wire logic                 presetn,    // async reset, active low
	input  wire logic                 ce,         // clock enable, freezes all state
	input  wire logic                 psel,       // apb select
	input  wire logic                 penable,    // apb access phase
	input  wire logic                 pwrite,     // apb direction
	input  wire logic [PADDR_W-1:0]   paddr,      // apb byte address
	input  wire logic [PDATA_W-1:0]   pwdata,     // apb write data
	output logic      [PDATA_W-1:0]   prdata,     // apb read data
	output logic                      pready,     // apb ready
	output logic                      pslverr,    // apb error on unmapped address
	input  wire logic [NSRC-1:0]      req_src,    // request source pins, asynchronous
	output logic                      xfer_valid, // transfer command valid
	input  wire logic                 xfer_ready, // transfer command taken
	output logic                      xfer_chan,  // channel of the command
	output logic      [ADDR_W-1:0]    xfer_addr,  // forward address of the command
	output logic      [NCHAN-1:0]     chan_active // enable bits of both channels
);
	import dmacr_pkg::*;

	initial begin
		if (ADDR_W < 1 || ADDR_W > PDATA_W)
			$error("pointer width must be 1..32");
		if (CNT_W < 1 || CNT_W > PDATA_W)
			$error("counter width must be 1..32");
		if (FIFO_DEPTH < 2)
			$error("fifo depth must be at least 2");
	end

	localparam int FW = ADDR_W + 1;

	// per channel state
	logic [NCHAN-1:0]                 en_r, en_nxt;
	logic [NCHAN-1:0]                 req_r, req_nxt;
	logic [NCHAN-1:0]                 dir_r, dir_nxt;
	logic [NCHAN-1:0][SEL_W-1:0]      sel_r, sel_nxt;
	logic [NCHAN-1:0][ADDR_W-1:0]     src_r, src_nxt;
	logic [NCHAN-1:0][ADDR_W-1:0]     dst_r, dst_nxt;
	logic [NCHAN-1:0][ADDR_W-1:0]     fwd_r, fwd_nxt;
	logic [NCHAN-1:0][CNT_W-1:0]      rld_r, rld_nxt;
	logic [NCHAN-1:0][CNT_W-1:0]      cnt_r, cnt_nxt;
	// request source edge detection
	logic [NSRC-1:0]                  src_sync;
	logic [NSRC-1:0]                  src_prev_r, src_prev_nxt;
	// apb answer
	logic [PDATA_W-1:0]               prdata_nxt, rd_word;
	logic                             pready_nxt, pslverr_nxt;
	// transfer start
	logic [NCHAN-1:0]                 reload, want, go;
	logic                             f_in_ready, f_in_valid;
	logic [FW-1:0]                    f_in_data, f_out_data;
	logic                             access, wr_take, hit;
	logic [2:0]                       reg_idx;
	logic                             chan_idx;

	// register window decode, shared by read and write paths
	function automatic logic addr_hit(input logic [PADDR_W-1:0] a);
		addr_hit = (a[1:0] == 2'h0) && (a[PADDR_W-1:CHAN_BIT+1] == '0)
			&& (a[4:2] <= REG_COUNT);
	endfunction : addr_hit

	function automatic logic [2:0] addr_reg(input logic [PADDR_W-1:0] a);
		addr_reg = a[4:2];
	endfunction : addr_reg

	dmacr_sync #(
		.W (NSRC)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       (req_src),
		.q       (src_sync)
	);

	dmacr_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (xfer_valid),
		.out_ready (xfer_ready),
		.out_data  (f_out_data)
	);

	assign xfer_chan   = f_out_data[FW-1];
	assign xfer_addr   = f_out_data[ADDR_W-1:0];
	assign chan_active = en_r;

	// common decode of the current apb access
	assign access   = psel && penable;
	assign wr_take  = access && pready && pwrite;
	assign hit      = addr_hit(paddr);
	assign reg_idx  = addr_reg(paddr);
	assign chan_idx = paddr[CHAN_BIT];

	// start arbitration: channel_zero wins a tie, a full fifo stalls both
	always_comb begin
		for (int c = 0; c < NCHAN; c++) begin
			reload[c] = wr_take && hit && (chan_idx == c[0]) && (reg_idx == REG_CTRL)
				&& pwdata[CTRL_EN_BIT];
			want[c]   = en_r[c] && req_r[c] && !reload[c];
		end
		go[0] = want[0] && f_in_ready;
		go[1] = want[1] && f_in_ready && !want[0];
		f_in_valid = |go;
		f_in_data  = go[0] ? {1'b0, fwd_r[0]} : {1'b1, fwd_r[1]};
	end

	// channel state update, each channel sees only its own window
	always_comb begin
		en_nxt       = en_r;
		req_nxt      = req_r;
		dir_nxt      = dir_r;
		sel_nxt      = sel_r;
		src_nxt      = src_r;
		dst_nxt      = dst_r;
		fwd_nxt      = fwd_r;
		rld_nxt      = rld_r;
		cnt_nxt      = cnt_r;
		src_prev_nxt = src_sync;
		for (int c = 0; c < NCHAN; c++) begin
			logic             wsel;
			logic             ctrl_w;
			logic [SEL_W-1:0] new_sel;
			logic             new_dir;
			wsel    = wr_take && hit && (chan_idx == c[0]);
			ctrl_w  = wsel && (reg_idx == REG_CTRL);
			new_sel = pwdata[CTRL_SEL_LSB +: SEL_W];
			new_dir = pwdata[CTRL_DIR_BIT];
			if (wsel && reg_idx == REG_SRC)
				src_nxt[c] = pwdata[ADDR_W-1:0];
			if (wsel && reg_idx == REG_DST)
				dst_nxt[c] = pwdata[ADDR_W-1:0];
			if (wsel && reg_idx == REG_RELOAD)
				rld_nxt[c] = pwdata[CNT_W-1:0];
			// a started transfer is applied first so that a restart overrides it
			if (go[c]) begin
				req_nxt[c] = 1'b0;
				fwd_nxt[c] = ADDR_W'(fwd_r[c] + 1'b1);
				cnt_nxt[c] = CNT_W'(cnt_r[c] - 1'b1);
				if (cnt_r[c] <= CNT_W'(1))
					en_nxt[c] = 1'b0;
			end
			if (ctrl_w) begin
				sel_nxt[c] = new_sel;
				dir_nxt[c] = new_dir;
				en_nxt[c]  = pwdata[CTRL_EN_BIT];
				if (!pwdata[CTRL_REQ_BIT])
					req_nxt[c] = 1'b0;
			end
			if (reload[c]) begin
				fwd_nxt[c] = new_dir ? dst_r[c] : src_r[c];
				cnt_nxt[c] = rld_r[c];
			end
			// set beats every clear in the same cycle, so no request is lost
			if (src_sync[sel_r[c]] && !src_prev_r[sel_r[c]])
				req_nxt[c] = 1'b1;
			if (ctrl_w && (new_sel != sel_r[c]) && src_sync[new_sel])
				req_nxt[c] = 1'b1;
		end
	end

	// read mux; the flag reads live so a busy channel mostly shows zero here
	always_comb begin
		rd_word = '0;
		if (hit) begin
			unique case (reg_idx)
				REG_CTRL: begin
					rd_word[CTRL_SEL_LSB +: SEL_W] = sel_r[chan_idx];
					rd_word[CTRL_REQ_BIT]          = req_r[chan_idx];
					rd_word[CTRL_EN_BIT]           = en_r[chan_idx];
					rd_word[CTRL_DIR_BIT]          = dir_r[chan_idx];
				end
				REG_SRC:    rd_word[ADDR_W-1:0] = src_r[chan_idx];
				REG_DST:    rd_word[ADDR_W-1:0] = dst_r[chan_idx];
				REG_FWD:    rd_word[ADDR_W-1:0] = fwd_r[chan_idx];
				REG_RELOAD: rd_word[CNT_W-1:0]  = rld_r[chan_idx];
				REG_COUNT:  rd_word[CNT_W-1:0]  = cnt_r[chan_idx];
				default:    rd_word = '0;
			endcase
		end
	end

	// one wait state: ready is raised in the second access cycle
	always_comb begin
		pready_nxt  = access && !pready;
		pslverr_nxt = access && !pready && !hit;
		prdata_nxt  = prdata;
		if (access && !pready)
			prdata_nxt = pwrite ? '0 : rd_word;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r       <= {NCHAN{EN_RST}};
			req_r      <= {NCHAN{REQ_RST}};
			dir_r      <= {NCHAN{DIR_RST}};
			sel_r      <= {NCHAN{SEL_RST}};
			src_r      <= '0;
			dst_r      <= '0;
			fwd_r      <= '0;
			rld_r      <= '0;
			cnt_r      <= '0;
			src_prev_r <= '0;
		end else if (ce) begin
			en_r       <= en_nxt;
			req_r      <= req_nxt;
			dir_r      <= dir_nxt;
			sel_r      <= sel_nxt;
			src_r      <= src_nxt;
			dst_r      <= dst_nxt;
			fwd_r      <= fwd_nxt;
			rld_r      <= rld_nxt;
			cnt_r      <= cnt_nxt;
			src_prev_r <= src_prev_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			prdata  <= prdata_nxt;
			pready  <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end
endmodule : dmacr_top

// ---- verif/dmacr_far_model.sv ----
// far side model: request source lines and a command consumer that can stall
`timescale 1ns/100ps
module dmacr_far_model (
	input  wire logic        pclk,       // system clock
	input  wire logic        stall,      // hold the consumer off
	input  wire logic        xfer_valid, // command valid
	input  wire logic        xfer_chan,  // command channel
	input  wire logic [19:0] xfer_addr,  // command address
	output logic      [3:0]  req_src,    // request lines
	output logic             xfer_ready  // command taken
);
	logic [20:0] got[$];
	initial req_src = 4'h0;
	// consumer logs each taken command; ready is the inverse of stall, one cycle late
	always @(posedge pclk) begin
		if (xfer_valid === 1'b1 && xfer_ready) got.push_back({xfer_chan, xfer_addr});
		xfer_ready <= !stall;
	end
	// one request: held long enough to pass the synchroniser, then low again
	task pulse(input int n);
		@(posedge pclk) req_src[n] <= 1'b1;
		repeat (4) @(posedge pclk);
		req_src[n] <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : pulse
	// level on one line, used to provoke a set on a select change
	task hold(input int n, input logic v);
		@(posedge pclk) req_src[n] <= v;
	endtask : hold
endmodule : dmacr_far_model

// ---- verif/dmacr_top_properties.sv ----
// concurrent checks on the ports of the transfer controller top
`timescale 1ns/100ps
module dmacr_top_chk
	import dmacr_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF
) (
	input wire logic               pclk,        // clock
	input wire logic               presetn,     // reset, active low
	input wire logic               ce,          // clock enable
	input wire logic               psel,        // apb select
	input wire logic               penable,     // apb access
	input wire logic               pwrite,      // apb direction
	input wire logic [PADDR_W-1:0] paddr,       // apb address
	input wire logic [PDATA_W-1:0] pwdata,      // apb write data
	input wire logic [PDATA_W-1:0] prdata,      // apb read data
	input wire logic               pready,      // apb ready
	input wire logic               pslverr,     // apb error
	input wire logic [NSRC-1:0]    req_src,     // request lines
	input wire logic               xfer_valid,  // command valid
	input wire logic               xfer_ready,  // command taken
	input wire logic               xfer_chan,   // command channel
	input wire logic [ADDR_W-1:0]  xfer_addr,   // command address
	input wire logic [NCHAN-1:0]   chan_active  // enable bits
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed control writes per channel
	logic ack, cw0, cw1;
	assign ack = psel && penable && pready;
	assign cw0 = ack && pwrite && paddr == 8'h00;
	assign cw1 = ack && pwrite && paddr == 8'h20;
	// setup cycle followed by the first access cycle
	sequence acc_s;
		psel && !penable ##1 psel && penable;
	endsequence
	ready_wait_a: assert property (acc_s |=> pready) else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	bad_addr_a: assert property (acc_s ##0 (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0)
		|=> pslverr) else $error("no error on unmapped address");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
	en_set_a: assert property (cw0 && pwdata[3] |=> chan_active[0]) else $error("enable not set");
	en_clr_a: assert property (cw1 && !pwdata[3] |=> !chan_active[1]) else $error("enable not cleared");
	rise_zero_a: assert property ($rose(chan_active[0]) |-> $past(cw0)) else $error("ch0 enable rose");
	rise_one_a: assert property ($rose(chan_active[1]) |-> $past(cw1)) else $error("ch1 enable rose");
	cmd_hold_a: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_addr)
		&& $stable(xfer_chan)) else $error("command dropped");
endmodule : dmacr_top_chk

bind dmacr_top dmacr_top_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .req_src(req_src),
	.xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_chan(xfer_chan),
	.xfer_addr(xfer_addr), .chan_active(chan_active));

// ---- verif/dmacr_top_tb.sv ----
// self-checking bench for the transfer controller enable and request logic
`timescale 1ns/100ps
module dmacr_top_tb;
	import dmacr_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
	logic        xfer_valid, xfer_ready, xfer_chan, stall;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  req_src;
	logic [19:0] xfer_addr;
	logic [1:0]  chan_active;
	int          n_fail, checks;
	dmacr_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_src(req_src), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
		.xfer_chan(xfer_chan), .xfer_addr(xfer_addr), .chan_active(chan_active));
	dmacr_far_model far (.pclk(pclk), .stall(stall), .xfer_valid(xfer_valid),
		.xfer_chan(xfer_chan), .xfer_addr(xfer_addr), .req_src(req_src), .xfer_ready(xfer_ready));
	// 40 mhz clock
	always #12.5 pclk = ~pclk;
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// one apb transfer; waits for ready without assuming a latency
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 50) n_fail++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	// next command taken by the far side, bounded wait
	task cmd(input logic [20:0] e);
		int k;
		for (k = 0; k < 100 && far.got.size() == 0; k++) @(posedge pclk);
		if (far.got.size() == 0) chk(32'hdead, {11'h0, e});
		else chk({11'h0, far.got.pop_front()}, {11'h0, e});
	endtask : cmd
	// hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		end_of_test;
	end
	// main sequence; clock enable stays high throughout
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, stall} = '0;
		ce = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h00, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, 8'h41, 32'h0);
		chk(er, 1'b1);
		wr(8'h04, 32'h100);
		wr(8'h10, 32'h5);
		wr(8'h28, 32'h201);
		wr(8'h30, 32'h2);
		wr(8'h00, 32'h08);
		// the write lands at the edge the task returns on, so look one edge later
		@(posedge pclk);
		chk(chan_active, 2'b01);
		rdc(8'h0c, 32'h100);
		rdc(8'h14, 32'h5);
		far.pulse(0);
		cmd({1'b0, 20'h100});
		rdc(8'h00, 32'h08);
		rdc(8'h14, 32'h4);
		wr(8'h00, 32'h08);
		rdc(8'h0c, 32'h100);
		rdc(8'h14, 32'h5);
		wr(8'h20, 32'h01);
		far.pulse(1);
		rdc(8'h20, 32'h05);
		wr(8'h20, 32'h01);
		rdc(8'h20, 32'h01);
		wr(8'h20, 32'h05);
		rdc(8'h20, 32'h01);
		// select a line that is already high, then discard any pending set
		far.hold(2, 1'b1);
		repeat (4) @(posedge pclk);
		wr(8'h20, 32'h02);
		rdc(8'h20, 32'h06);
		wr(8'h20, 32'h02);
		rdc(8'h20, 32'h02);
		far.hold(2, 1'b0);
		wr(8'h20, 32'h19);
		rdc(8'h2c, 32'h201);
		chk(chan_active, 2'b11);
		far.pulse(1);
		cmd({1'b1, 20'h201});
		far.pulse(1);
		cmd({1'b1, 20'h202});
		chk(chan_active, 2'b01);
		// fill the buffer with the consumer stalled; the fifth request waits
		@(posedge pclk) stall <= 1'b1;
		repeat (5) far.pulse(0);
		rdc(8'h00, 32'h0c);
		@(posedge pclk) stall <= 1'b0;
		for (int i = 0; i < 5; i++) cmd({1'b0, 20'h100 + 20'(i)});
		chk(chan_active, 2'b00);
		end_of_test;
	end
endmodule : dmacr_top_tb
